// ==== design/tpcd_edge.sv ====
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------------------
// Request edge tracker
// ------------------------------------------------------------------------
module tpcd_edge (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic req_in,
  output logic      rise_out,
  output logic      xon_out
);

  logic prev_r;
  logic long_r;

  // Rise pulse, and a fall pulse only after a run longer than one cycle
  assign rise_out = req_in & ~prev_r;
  assign xon_out  = ~req_in & prev_r & long_r;

  // Track the previous level and whether it stood for two cycles
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_r <= 1'b0;
      long_r <= 1'b0;
    end else begin
      prev_r <= req_in;
      long_r <= req_in & prev_r;
    end
  end

endmodule

`default_nettype wire

// ==== design/tpcd_pkg.sv ====
package tpcd_pkg;

  // ----------------------------------------------------------------------
  // Setup vector field positions
  // ----------------------------------------------------------------------
  localparam int CFG_W          = 144;
  localparam int BIT_PRIO1_EN   = 89;
  localparam int BIT_PRIO0_EN   = 88;
  localparam int BIT_AUTO_XON   = 81;
  localparam int BIT_PFC_EN     = 80;
  localparam int ADDR_LO        = 32;
  localparam int MAXLEN_LO      = 16;
  localparam int BIT_MAXFR_EN   = 14;
  localparam int BIT_FC_EN      = 5;
  localparam int BIT_JUMBO_EN   = 4;
  localparam int Q0_LO          = 96;
  localparam int Q1_LO          = 128;

  // ----------------------------------------------------------------------
  // Frame sizes and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] LEGAL_MAX_LEN = 16'h05EE; // 1518 bytes
  localparam logic [15:0] NO_LIMIT_LEN  = 16'hFFFF;
  localparam logic [47:0] ADDR_RST      = 48'h0000_0000_0000;
  localparam logic [15:0] QUANTA_RST    = 16'h0000;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    TPCD_KIND_NONE  = 2'b00,
    TPCD_KIND_PAUSE = 2'b01,
    TPCD_KIND_PFC   = 2'b10
  } tpcd_kind_e;

  typedef struct packed {
    tpcd_kind_e  kind;
    logic [1:0]  prio_mask;
    logic [15:0] quanta0;
    logic [15:0] quanta1;
    logic [47:0] src_addr;
  } tpcd_fc_req_s;

endpackage

// ==== design/tpcd_top.sv ====
`timescale 1ns/10ps
`default_nettype none

module tpcd_top #(
  parameter int CFG_W = tpcd_pkg::CFG_W
) (
  input  wire logic               mclk_in,
  input  wire logic               rst_n_in,
  input  wire logic [CFG_W-1:0]   setup_vec_in,
  input  wire logic               prio0_req_valid_in,
  input  wire logic               prio1_req_valid_in,
  input  wire logic               pause_req_in,
  input  wire logic [15:0]        pause_val_in,
  input  wire logic               fc_ack_in,
  input  wire logic [47:0]        rx_fc_dest_in,
  input  wire logic               rx_fc_valid_in,
  input  wire logic [15:0]        tx_frame_len_in,
  output tpcd_pkg::tpcd_fc_req_s  fc_req_out,
  output logic                    fc_req_valid_out,
  output logic [47:0]             src_addr_out,
  output logic [7:0]              first_byte_out,
  output logic                    rx_fc_match_out,
  output logic [15:0]             max_len_out,
  output logic                    len_ok_out
);

  // ----------------------------------------------------------------------
  // Setup field decode
  // ----------------------------------------------------------------------
  // Only named fields are sliced; reserved bits fall away here
  wire logic        prio1_en_w = setup_vec_in[tpcd_pkg::BIT_PRIO1_EN];
  wire logic        prio0_en_w = setup_vec_in[tpcd_pkg::BIT_PRIO0_EN];
  wire logic        auto_xon_w = setup_vec_in[tpcd_pkg::BIT_AUTO_XON];
  wire logic        pfc_en_w   = setup_vec_in[tpcd_pkg::BIT_PFC_EN];
  wire logic        fc_en_w    = setup_vec_in[tpcd_pkg::BIT_FC_EN];
  wire logic        maxfr_w    = setup_vec_in[tpcd_pkg::BIT_MAXFR_EN];
  wire logic        jumbo_w    = setup_vec_in[tpcd_pkg::BIT_JUMBO_EN];
  // Address kept in wire order: bits 7:0 are the first byte out and
  // bit 0, the group flag, is the first bit sent
  wire logic [47:0] addr_w     =
    setup_vec_in[tpcd_pkg::ADDR_LO +: 48];
  wire logic [15:0] maxlen_w   = setup_vec_in[tpcd_pkg::MAXLEN_LO +: 16];
  wire logic [15:0] q0_w       = setup_vec_in[tpcd_pkg::Q0_LO +: 16];
  wire logic [15:0] q1_w       = setup_vec_in[tpcd_pkg::Q1_LO +: 16];

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Release frames carry zero quanta so the far end resumes at once
  function automatic logic [15:0] quanta_pick(
    input logic        xon,
    input logic [15:0] prog
  );
    return xon ? tpcd_pkg::QUANTA_RST : prog;
  endfunction

  // ----------------------------------------------------------------------
  // Request edge tracking
  // ----------------------------------------------------------------------
  // One tracker per request line; rise and release strobes are each
  // one cycle wide
  logic rise0_w, xon0_w, rise1_w, xon1_w, rise_p_w, xon_p_w;

  // Priority 0 valid
  tpcd_edge u_edge0 (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .req_in   (prio0_req_valid_in),
    .rise_out (rise0_w),
    .xon_out  (xon0_w)
  );

  // Priority 1 valid
  tpcd_edge u_edge1 (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .req_in   (prio1_req_valid_in),
    .rise_out (rise1_w),
    .xon_out  (xon1_w)
  );

  // Ordinary pause request
  tpcd_edge u_edge_p (
    .mclk_in  (mclk_in),
    .rst_n_in (rst_n_in),
    .req_in   (pause_req_in),
    .rise_out (rise_p_w),
    .xon_out  (xon_p_w)
  );

  // ----------------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------------
  // Master enable gates every priority source
  wire logic p0_on_w  = pfc_en_w & prio0_en_w;
  wire logic p1_on_w  = pfc_en_w & prio1_en_w;
  wire logic p0_go_w  = p0_on_w & rise0_w;
  wire logic p1_go_w  = p1_on_w & rise1_w;
  wire logic p0_xon_w = p0_on_w & auto_xon_w & xon0_w;
  wire logic p1_xon_w = p1_on_w & auto_xon_w & xon1_w;

  // Ordinary pause follows its own enable, not the master enable;
  // both together are not blocked here, user logic keeps them apart
  wire logic ps_go_w  = fc_en_w & rise_p_w;
  wire logic ps_xon_w = fc_en_w & auto_xon_w & xon_p_w;

  // Any event of either class asks for a load
  wire logic pfc_any_w = p0_go_w | p1_go_w | p0_xon_w | p1_xon_w;
  wire logic ps_any_w  = ps_go_w | ps_xon_w;

  // Priorities firing in one cycle share a single frame
  wire logic [1:0] mask_w = {p1_go_w | p1_xon_w, p0_go_w | p0_xon_w};

  // Quanta per slot: programmed value on assert, zero on release
  wire logic [15:0] q0_sel_w = quanta_pick(p0_xon_w, q0_w);
  wire logic [15:0] q1_sel_w = quanta_pick(p1_xon_w, q1_w);
  wire logic [15:0] qp_sel_w = quanta_pick(ps_xon_w, pause_val_in);

  // Priority frames win over the ordinary pause; a request waiting for
  // acknowledge is held and new events then are dropped, not queued.
  tpcd_pkg::tpcd_fc_req_s req_nxt;
  always_comb begin
    req_nxt           = fc_req_out;
    req_nxt.src_addr  = addr_w;
    if (pfc_any_w) begin
      req_nxt.kind      = tpcd_pkg::TPCD_KIND_PFC;
      req_nxt.prio_mask = mask_w;
      req_nxt.quanta0   = q0_sel_w;
      req_nxt.quanta1   = q1_sel_w;
    end else begin
      req_nxt.kind      = tpcd_pkg::TPCD_KIND_PAUSE;
      req_nxt.prio_mask = 2'b00;
      req_nxt.quanta0   = qp_sel_w;
      req_nxt.quanta1   = tpcd_pkg::QUANTA_RST;
    end
  end

  // A slot is free when nothing waits or the waiting one is taken
  // now, so an ack beside a new event hands over without a gap;
  // the new request then replaces the one just taken
  wire logic slot_free_w = !fc_req_valid_out || fc_ack_in;
  wire logic load_w      = slot_free_w && (pfc_any_w || ps_any_w);

  // ----------------------------------------------------------------------
  // Frame size limit
  // ----------------------------------------------------------------------
  // Jumbo beats max-frame, which beats the legal maximum. A length
  // field below 1518 is used as given; keeping it legal is up to
  // user logic
  wire logic [15:0] max_nxt =
    jumbo_w ? tpcd_pkg::NO_LIMIT_LEN :
    maxfr_w ? maxlen_w :
              tpcd_pkg::LEGAL_MAX_LEN;

  // Length check against the limit that the setup vector selects
  wire logic len_fit_w = (tx_frame_len_in <= max_nxt);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Request holds until acknowledged; its fields do not move
  // while it waits
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fc_req_out       <= '0;
      fc_req_valid_out <= 1'b0;
    end else if (load_w) begin
      fc_req_out       <= req_nxt;
      fc_req_valid_out <= 1'b1;
    end else if (fc_ack_in) begin
      fc_req_valid_out <= 1'b0;
    end
  end

  // Pause source address and the byte that leads on the wire
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_addr_out   <= tpcd_pkg::ADDR_RST;
      first_byte_out <= 8'h00;
    end else begin
      src_addr_out   <= addr_w;
      first_byte_out <= addr_w[7:0];
    end
  end

  // Limit and length check move together, one cycle behind setup
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      max_len_out <= tpcd_pkg::LEGAL_MAX_LEN;
      len_ok_out  <= 1'b0;
    end else begin
      max_len_out <= max_nxt;
      len_ok_out  <= len_fit_w;
    end
  end

  // Receive match is gated by its qualifier and is low the cycle after it is low
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_fc_match_out <= 1'b0;
    end else begin
      rx_fc_match_out <= rx_fc_valid_in &&
                         (rx_fc_dest_in == addr_w);
    end
  end

endmodule

`default_nettype wire

// ==== tb/tpcd_top_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpcd_top_sva #(
  parameter int CFG_W = tpcd_pkg::CFG_W
) (
  input wire logic                   mclk_in,
  input wire logic                   rst_n_in,
  input wire logic [CFG_W-1:0]       setup_vec_in,
  input wire logic                   prio0_req_valid_in,
  input wire logic [47:0]            rx_fc_dest_in,
  input wire logic                   rx_fc_valid_in,
  input wire logic [15:0]            tx_frame_len_in,
  input wire tpcd_pkg::tpcd_fc_req_s fc_req_out,
  input wire logic                   fc_req_valid_out,
  input wire logic [47:0]            src_addr_out,
  input wire logic [7:0]             first_byte_out,
  input wire logic                   rx_fc_match_out,
  input wire logic [15:0]            max_len_out,
  input wire logic                   len_ok_out
);
  logic        live_r;
  logic [15:0] lim;
  logic        p0_ok;
  // Size limit and priority-0 acceptance
  assign lim = setup_vec_in[4] ? 16'hFFFF :
               (setup_vec_in[14] ? setup_vec_in[31:16] : 16'h05EE);
  assign p0_ok = setup_vec_in[80] && setup_vec_in[88] && !fc_req_valid_out;
  // First edge after reset has no valid history
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      live_r <= 1'b0;
    else
      live_r <= 1'b1;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_p0_rise;
    !prio0_req_valid_in ##1 prio0_req_valid_in;
  endsequence
  sequence s_p0_fall;
    prio0_req_valid_in [*2] ##1 !prio0_req_valid_in;
  endsequence
  a_p0_start: assert property (s_p0_rise ##0 p0_ok |=>
    fc_req_valid_out && fc_req_out.prio_mask[0] &&
    fc_req_out.quanta0 == setup_vec_in[111:96]) else $error("p0 start");
  a_p0_xon: assert property (s_p0_fall ##0 (p0_ok && setup_vec_in[81])
    |=> fc_req_valid_out && fc_req_out.quanta0 == 16'h0000)
    else $error("p0 xon");
  a_pfc_gate: assert property ($rose(fc_req_valid_out) &&
    fc_req_out.kind == tpcd_pkg::TPCD_KIND_PFC |-> $past(setup_vec_in[80]))
    else $error("pfc gate");
  a_p0_gate: assert property ($rose(fc_req_valid_out) &&
    fc_req_out.prio_mask[0] |-> $past(setup_vec_in[88])) else $error("p0");
  a_addr_copy: assert property (live_r |->
    src_addr_out == $past(setup_vec_in[79:32])) else $error("addr");
  a_first_byte: assert property (
    first_byte_out == src_addr_out[7:0]) else $error("first byte");
  a_rx_match: assert property (live_r |-> rx_fc_match_out ==
    $past(rx_fc_valid_in && rx_fc_dest_in == setup_vec_in[79:32]))
    else $error("rx match");
  a_max_len: assert property (live_r |-> max_len_out == $past(lim) &&
    len_ok_out == ($past(tx_frame_len_in) <= $past(lim))) else $error("len");
endmodule
bind tpcd_top tpcd_top_sva #(.CFG_W(CFG_W)) u_sva (.mclk_in, .rst_n_in,
  .setup_vec_in, .prio0_req_valid_in, .rx_fc_dest_in, .rx_fc_valid_in,
  .tx_frame_len_in, .fc_req_out, .fc_req_valid_out, .src_addr_out,
  .first_byte_out, .rx_fc_match_out, .max_len_out, .len_ok_out);
`default_nettype wire

// ==== tb/tpcd_user_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module tpcd_user_model (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       valid_in,
  input  wire logic [1:0] lat_in,
  output logic            ack_out
);
  logic [1:0] wait_r;
  logic       busy;
  assign busy = valid_in && !ack_out;
  // Slow taker: acks after lat_in idle cycles
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_r  <= 2'h0;
      ack_out <= 1'b0;
    end else begin
      ack_out <= busy && (wait_r == lat_in);
      wait_r  <= (busy && wait_r != lat_in) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ==== tb/tx_pause_pfc_config_decode_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tx_pause_pfc_config_decode_tb;
  logic mclk_in = 1'b0, rst_n_in = 1'b1, fc_ack_in, rx_fc_valid_in = 1'b0;
  logic prio0_req_valid_in = 1'b0, prio1_req_valid_in = 1'b0;
  logic pause_req_in = 1'b0, fc_req_valid_out, rx_fc_match_out, len_ok_out;
  logic [143:0] setup_vec_in = 144'h0, v;
  logic [15:0]  pause_val_in = 16'h0000, tx_frame_len_in = 16'h0000;
  logic [15:0]  max_len_out;
  logic [47:0]  rx_fc_dest_in = 48'h0, src_addr_out;
  logic [7:0]   first_byte_out;
  logic [6:0]   f;
  logic [1:0]   lat = 2'h0;
  logic [8:0]   dir [7] = '{9'h0E0, 9'h121, 9'h0A1, 9'h080, 9'h052,
                             9'h182, 9'h161};
  tpcd_pkg::tpcd_fc_req_s fc_req_out, r;
  int fails = 0, n_tests = 0, seed;
  always #5 mclk_in = ~mclk_in;
  tpcd_top uut (.mclk_in, .rst_n_in, .setup_vec_in, .prio0_req_valid_in,
    .prio1_req_valid_in, .pause_req_in, .pause_val_in, .fc_ack_in,
    .rx_fc_dest_in, .rx_fc_valid_in, .tx_frame_len_in, .fc_req_out,
    .fc_req_valid_out, .src_addr_out, .first_byte_out, .rx_fc_match_out,
    .max_len_out, .len_ok_out);
  tpcd_user_model u_user (.mclk_in, .rst_n_in, .valid_in(fc_req_valid_out),
    .lat_in(lat), .ack_out(fc_ack_in));
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Random vector, reserved bits left random on purpose
  function automatic logic [143:0] mk(input logic [6:0] g);
    logic [143:0] s;
    s = 144'({$urandom, $urandom, $urandom, $urandom, $urandom});
    {s[89], s[88], s[81], s[80], s[5], s[14], s[4]} = g;
    s[5] = s[5] & ~s[80];
    s[31:16] = 16'h05EE + {7'h00, s[24:16]};
    return s;
  endfunction
  function automatic logic [15:0] lim(input logic [143:0] s);
    return s[4] ? 16'hFFFF : (s[14] ? s[31:16] : 16'h05EE);
  endfunction
  // First pending request seen within three edges
  task automatic grab(output logic got);
    got = 1'b0;
    repeat (3) begin
      @(posedge mclk_in);
      #1;
      if (!got) r = fc_req_out;
      got = got | (fc_req_valid_out === 1'b1);
    end
  endtask
  task automatic req_test(input logic [6:0] g, input int w);
    logic got, e;
    e = (w == 2) ? g[2] : g[3] & g[5 + w];
    @(posedge mclk_in);
    lat <= 2'($urandom_range(3));
    setup_vec_in <= mk(g);
    repeat (6) @(posedge mclk_in);
    {pause_req_in, prio1_req_valid_in, prio0_req_valid_in} <= 3'h1 << w;
    grab(got);
    chk(got === e, "gating");
    chk(!e || (r.kind === (w == 2 ? tpcd_pkg::TPCD_KIND_PAUSE :
      tpcd_pkg::TPCD_KIND_PFC) && r.src_addr === setup_vec_in[79:32]), "kind");
    chk(!e || w == 2 || (r.prio_mask[w] === 1'b1 &&
      r.prio_mask[1 - w] === 1'b0 && (w == 1 ?
      r.quanta1 === setup_vec_in[143:128] :
      r.quanta0 === setup_vec_in[111:96])), "slot");
    repeat (8) @(posedge mclk_in);
    {pause_req_in, prio1_req_valid_in, prio0_req_valid_in} <= 3'h0;
    grab(got);
    chk(got === (e & g[4]), "xon");
    chk(!got || (w == 1 ? r.quanta1 : r.quanta0) === 16'h0000, "xq");
  endtask
  initial begin
    rst_n_in <= 1'b0;
    seed = $urandom(32'h1EFB5FB1);
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    pause_val_in <= 16'($urandom);
    foreach (dir[i]) req_test(dir[i][8:2], int'(dir[i][1:0]));
    repeat (10) begin
      f = 7'($urandom);
      f[2] = f[2] & ~f[3];
      req_test(f, $urandom_range(2));
    end
    repeat (24) begin
      @(posedge mclk_in);
      v = mk(7'($urandom));
      setup_vec_in <= v;
      tx_frame_len_in <= 16'h05D0 + 16'($urandom_range(1024));
      rx_fc_valid_in <= 1'($urandom_range(1));
      rx_fc_dest_in <= $urandom_range(1) ? v[79:32] :
        48'({$urandom, $urandom});
      repeat (2) @(posedge mclk_in);
      #1;
      chk(max_len_out === lim(v) && len_ok_out ===
        (tx_frame_len_in <= lim(v)), "size");
      chk(rx_fc_match_out === (rx_fc_valid_in &&
        rx_fc_dest_in == v[79:32]), "match");
      chk(src_addr_out === v[79:32] && first_byte_out === v[39:32],
        "address");
    end
    summarize();
  end
  // Watchdog against a hung handshake
  initial begin
    #50000;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
